/* File: pkg/touch_pkg.sv */
// package: constants and field layout of the dual touch sense controller
// Contract
// RL1 - channel 0 always, channel 1 by enable
// RL2 - calibration request runs, then completion flag
// RL3 - calibration picks waveform type, host can see
// RL4 - one interrupt pin flags new sensor events
// RL5 - only enabled event types raise interrupt
// RL6 - host reads mask: event type and sensor
// RL7 - sleep between scans, 1 ms to 256 s
// RL8 - main clock selectable, 16 or 32 MHz
// RL9 - shift above press threshold means pressed
// RL10 - shift above proximity threshold means proximity
// RL11 - pressed too long forces button released
// RL12 - time-out of zero never forces release
// RL13 - host may set new slave address
// RL14 - state: released, pressed, proximity or fault
// RL15 - latest raw and tracking baseline per sensor
// RL16 - peak raw held, cleared by reset command
// RL17 - thresholds compare raw minus baseline
// RL18 - interrupt held until mask is read
package touch_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_TIME = 1; // time unit of sleep and time-out, in ms
   localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
   localparam int CH_N = 2;
   localparam int RAW_W = 16;
   localparam int SLEEP_W = 18;
   localparam logic [17:0] SLEEP_MIN = 18'h00001; // 1 ms
   localparam logic [17:0] SLEEP_MAX = 18'h3e800; // 256000 ms
   localparam int TMO_W = 16;
   localparam int EVT_N = 4;
   // sensor state codes, also event type index
   localparam logic [1:0] ST_RELEASED = 2'h0;
   localparam logic [1:0] ST_PRESSED = 2'h1;
   localparam logic [1:0] ST_PROX = 2'h2;
   localparam logic [1:0] ST_FAULT = 2'h3;
   // waveform choice made by calibration
   localparam logic [15:0] WAVE_LEVEL = 16'h2000;
   localparam logic WAVE_RST = 1'b0;
   // main clock select
   localparam logic CLK_SEL_16 = 1'b0;
   localparam logic CLK_SEL_32 = 1'b1;
   localparam logic CLK_SEL_RST = CLK_SEL_32;
   // slave address and byte framing
   localparam logic [6:0] I2C_ADDR_RST = 7'h25;
   localparam logic [3:0] I2C_LAST = 4'h8;
endpackage

/* File: src/scan_timer.sv */
// scan_timer: millisecond divider and sleep interval between scans
`timescale 1ns/1ps
module scan_timer #(
   parameter int MS_CYC = touch_pkg::MS_CYCLES
) (
   input wire logic clk, // core clock
   input wire logic rst, // synchronous reset, high
   input wire logic run, // count sleep while high
   input wire logic [touch_pkg::SLEEP_W-1:0] sleep_ms, // interval in ms
   output logic ms_tick, // one pulse per ms
   output logic scan_tick // one pulse when interval ends
);
   import touch_pkg::*;
   logic [31:0] div_q, div_d;
   logic [SLEEP_W-1:0] ms_q, ms_d;
   logic tick_q, tick_d;
   logic scan_q, scan_d;
   logic [SLEEP_W-1:0] limit;

   // clamp interval into its legal range, then count ms ticks
   always_comb begin
      limit = sleep_ms;
      if (sleep_ms < SLEEP_MIN) limit = SLEEP_MIN; // RL7
      if (sleep_ms > SLEEP_MAX) limit = SLEEP_MAX; // RL7
      tick_d = (div_q == 32'(MS_CYC - 1));
      div_d = tick_d ? 32'h0 : div_q + 32'h1;
      ms_d = ms_q;
      scan_d = 1'b0;
      if (!run) begin
         ms_d = '0;
      end else if (tick_q) begin
         if (ms_q + 18'h00001 >= limit) begin
            ms_d = '0;
            scan_d = 1'b1; // RL7
         end else begin
            ms_d = ms_q + 18'h00001;
         end
      end
   end

   // registers only
   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= 32'h0;
         ms_q <= '0;
         tick_q <= 1'b0;
         scan_q <= 1'b0;
      end else begin
         div_q <= div_d;
         ms_q <= ms_d;
         tick_q <= tick_d;
         scan_q <= scan_d;
      end
   end

   assign ms_tick = tick_q;
   assign scan_tick = scan_q;
endmodule // scan_timer

/* File: src/i2c_target.sv */
// i2c_target: slave that returns the state mask and takes a new address
`timescale 1ns/1ps
module i2c_target (
   input wire logic clk, // core clock
   input wire logic rst, // synchronous reset, high
   input wire logic scl_pin, // bus clock, asynchronous
   input wire logic sda_pin, // bus data level, asynchronous
   output logic sda_val, // data value driven, always low
   output logic sda_en, // high while pulling data low
   input wire logic [7:0] tx_byte, // byte returned on reads
   output logic rd_pulse, // one pulse per byte loaded for reading
   output logic [6:0] own_addr // current slave address
);
   import touch_pkg::*;
   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
   } i2c_state_t;
   i2c_state_t st_q, st_d;
   logic [2:0] scl_s_q, sda_s_q;
   logic [7:0] sh_q, sh_d;
   logic [3:0] cnt_q, cnt_d;
   logic en_q, en_d, rd_q, rd_d;
   logic [6:0] addr_q, addr_d;
   logic rise, fall, start, stop;

   // edges come from the second and third stages only
   assign rise = scl_s_q[1] & ~scl_s_q[2];
   assign fall = ~scl_s_q[1] & scl_s_q[2];
   assign start = scl_s_q[1] & sda_s_q[2] & ~sda_s_q[1];
   assign stop = scl_s_q[1] & ~sda_s_q[2] & sda_s_q[1];

   // byte framing: sample on rise, drive on fall
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      en_d = en_q;
      rd_d = 1'b0;
      addr_d = addr_q;
      if (start) begin
         st_d = I_ADDR;
         cnt_d = 4'h0;
         en_d = 1'b0;
      end else if (stop) begin
         st_d = I_IDLE;
         en_d = 1'b0;
      end else begin
         unique case (st_q)
            I_IDLE: ;
            I_ADDR, I_WR: begin
               if (rise && cnt_q != I2C_LAST) begin
                  sh_d = {sh_q[6:0], sda_s_q[1]};
                  cnt_d = cnt_q + 4'h1;
               end else if (fall && cnt_q == I2C_LAST) begin
                  en_d = 1'b1;
                  if (st_q == I_WR) begin
                     addr_d = sh_q[6:0]; // RL13
                     st_d = I_WACK;
                  end else if (sh_q[7:1] == addr_q) begin
                     st_d = I_AACK;
                  end else begin
                     en_d = 1'b0;
                     st_d = I_IDLE;
                  end
               end
            end
            I_AACK, I_WACK, I_RACK: begin
               if (st_q == I_RACK && rise && sda_s_q[1]) begin
                  st_d = I_IDLE; // host nack ends the read
               end else if (fall && (st_q != I_AACK || !sh_q[0])) begin
                  en_d = 1'b0;
                  cnt_d = 4'h0;
                  st_d = I_WR;
               end
               if (fall && st_q != I_WACK && (st_q == I_RACK || sh_q[0])) begin
                  sh_d = tx_byte; // RL6
                  en_d = ~tx_byte[7];
                  rd_d = 1'b1;
                  cnt_d = 4'h1;
                  st_d = I_RD;
               end
            end
            I_RD: begin
               if (fall) begin
                  if (cnt_q == I2C_LAST) begin
                     en_d = 1'b0;
                     st_d = I_RACK;
                  end else begin
                     en_d = ~sh_q[6];
                     sh_d = {sh_q[6:0], 1'b0};
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // registers only
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         st_q <= I_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         en_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= I2C_ADDR_RST;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_pin};
         sda_s_q <= {sda_s_q[1:0], sda_pin};
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         en_q <= en_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
      end
   end

   assign sda_val = 1'b0;
   assign sda_en = en_q;
   assign rd_pulse = rd_q;
   assign own_addr = addr_q;
endmodule // i2c_target

/* File: src/dual_touch_proximity_sense.sv */
// dual_touch_proximity_sense: scan, classify and report two touch sensors
`timescale 1ns/1ps
module dual_touch_proximity_sense #(
   parameter int MS_CYC = touch_pkg::MS_CYCLES // cycles per ms
) (
   input wire logic clk, // core clock, 40 MHz
   input wire logic rst, // synchronous reset, high
   // host bus
   input wire logic scl_pin, // bus clock level
   input wire logic sda_pin, // bus data level
   output logic sda_val, // data value, always low
   output logic sda_en, // high while pulling data low
   output logic irq, // event notification, high
   output logic [6:0] slave_addr, // current slave address
   // configuration
   input wire logic ch1_en, // channel 1 in use
   input wire logic clk_sel, // 0: 16 MHz, 1: 32 MHz
   input wire logic [touch_pkg::SLEEP_W-1:0] sleep_ms, // scan interval
   input wire logic [touch_pkg::RAW_W-1:0] press_th, // press threshold
   input wire logic [touch_pkg::RAW_W-1:0] prox_th, // proximity threshold
   input wire logic [touch_pkg::TMO_W-1:0] press_tmo, // ms, 0 is off
   input wire logic [touch_pkg::EVT_N-1:0] evt_en, // event type enables
   input wire logic [touch_pkg::CH_N-1:0] cal_req, // calibration pulses
   input wire logic peak_clr, // clear peak values, pulse
   // acquisition front end
   output logic acq_start, // start one conversion, pulse
   output logic acq_ch, // channel being converted
   input wire logic raw_valid, // conversion result ready, pulse
   input wire logic [touch_pkg::RAW_W-1:0] raw_in, // conversion result
   input wire logic raw_fault, // sensor shorted or open
   // status
   output logic core_clk_sel, // selected main clock
   output logic [touch_pkg::CH_N-1:0] cal_done, // calibration finished
   output logic [touch_pkg::CH_N-1:0] wave_sel, // chosen waveform type
   output logic [touch_pkg::CH_N-1:0][1:0] sense_state, // per channel
   output logic [touch_pkg::CH_N-1:0][touch_pkg::RAW_W-1:0] raw_val, // raw
   output logic [touch_pkg::CH_N-1:0][touch_pkg::RAW_W-1:0] base_val, // base
   output logic [touch_pkg::CH_N-1:0][touch_pkg::RAW_W-1:0] peak_val // peak
);
   import touch_pkg::*;

   typedef enum logic {
      S_SLEEP,
      S_WAIT
   } scan_state_t;

   // difference that stops at zero
   function automatic logic [RAW_W-1:0] sat_sub(
      input logic [RAW_W-1:0] a,
      input logic [RAW_W-1:0] b
   );
      sat_sub = (a > b) ? a - b : '0;
   endfunction

   // scan sequencer state
   scan_state_t state_q, state_d;
   logic ch_q, ch_d;
   logic start_q, start_d;
   logic clk_sel_q, clk_sel_d;

   // per channel state
   logic [CH_N-1:0][RAW_W-1:0] raw_q, raw_d;
   logic [CH_N-1:0][RAW_W-1:0] base_q, base_d;
   logic [CH_N-1:0][RAW_W-1:0] peak_q, peak_d;
   logic [CH_N-1:0][TMO_W-1:0] tmo_q, tmo_d;
   logic [CH_N-1:0][1:0] st_q, st_d;
   logic [CH_N-1:0] wave_q, wave_d;
   logic [CH_N-1:0] pend_q, pend_d;
   logic [CH_N-1:0] done_q, done_d;
   logic [CH_N-1:0] chg_q, chg_d;
   logic irq_q, irq_d;

   // links to the helpers
   logic ms_tick;
   logic scan_tick;
   logic mask_rd;
   logic [7:0] mask_byte;
   logic [CH_N-1:0] ch_on;
   logic cal_kick;

   // channel 0 always scanned, channel 1 only when enabled
   assign ch_on = {ch1_en, 1'b1}; // RL1

   // a pending calibration on a live channel starts a scan at once
   assign cal_kick = |(pend_q & ch_on);

   // sleep interval and millisecond base
   scan_timer #(
      .MS_CYC(MS_CYC)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .run(state_q == S_SLEEP),
      .sleep_ms(sleep_ms),
      .ms_tick(ms_tick),
      .scan_tick(scan_tick)
   );

   // mask: type codes in low nibble, changed sensors above
   assign mask_byte = {2'b00, chg_q, st_q[1], st_q[0]}; // RL6

   // host bus slave
   i2c_target u_bus (
      .clk(clk),
      .rst(rst),
      .scl_pin(scl_pin),
      .sda_pin(sda_pin),
      .sda_val(sda_val),
      .sda_en(sda_en),
      .tx_byte(mask_byte),
      .rd_pulse(mask_rd),
      .own_addr(slave_addr)
   );

   // scan sequencer: sleep, convert channel 0, then channel 1 when ch1_en is set
   always_comb begin
      state_d = state_q;
      ch_d = ch_q;
      start_d = 1'b0;
      clk_sel_d = clk_sel; // RL8
      unique case (state_q)
         S_SLEEP: begin
            if (scan_tick || cal_kick) begin // RL7 RL2
               ch_d = 1'b0;
               start_d = 1'b1;
               state_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (raw_valid) begin
               if (!ch_q && ch1_en) begin // RL1
                  ch_d = 1'b1;
                  start_d = 1'b1;
               end else begin
                  state_d = S_SLEEP;
               end
            end
         end
      endcase
   end

   // per channel classification, tracking and event capture
   always_comb begin
      logic [RAW_W-1:0] shift;
      logic [1:0] nst;
      logic hit;
      logic force_rel;
      shift = '0;
      nst = ST_RELEASED;
      hit = 1'b0;
      force_rel = 1'b0;
      raw_d = raw_q;
      base_d = base_q;
      peak_d = peak_q;
      tmo_d = tmo_q;
      st_d = st_q;
      wave_d = wave_q;
      pend_d = pend_q;
      done_d = done_q;
      chg_d = chg_q;
      // reading the mask clears the change bits; new sets win below
      if (mask_rd) begin
         chg_d = '0; // RL18
      end
      for (int i = 0; i < CH_N; i++) begin
         hit = (state_q == S_WAIT) && raw_valid && (ch_q == i[0]);
         nst = st_q[i];
         if (cal_req[i]) begin
            pend_d[i] = 1'b1;
            done_d[i] = 1'b0;
         end
         if (peak_clr) begin
            peak_d[i] = '0; // RL16
         end
         // time spent pressed, in ms
         if (st_q[i] == ST_PRESSED && ms_tick && tmo_q[i] != '1) begin
            tmo_d[i] = tmo_q[i] + 16'h0001;
         end
         force_rel = (st_q[i] == ST_PRESSED) && (press_tmo != '0) // RL12
            && (tmo_q[i] >= press_tmo); // RL11
         if (hit) begin
            raw_d[i] = raw_in; // RL15
            if (raw_in > peak_d[i]) begin
               peak_d[i] = raw_in; // RL16
            end
         end
         if (force_rel) begin
            // rebase on the stuck level so it does not press again
            nst = ST_RELEASED; // RL11
            base_d[i] = hit ? raw_in : raw_q[i];
         end else if (hit && pend_q[i]) begin
            base_d[i] = raw_in; // RL2
            wave_d[i] = (raw_in < WAVE_LEVEL); // RL3
            pend_d[i] = 1'b0;
            done_d[i] = 1'b1; // RL2
            nst = ST_RELEASED;
         end else if (hit && raw_fault) begin
            nst = ST_FAULT; // RL14
         end else if (hit) begin
            shift = sat_sub(raw_in, base_q[i]); // RL17
            if (shift > press_th) begin
               nst = ST_PRESSED; // RL9
            end else if (shift > prox_th) begin
               nst = ST_PROX; // RL10
            end else begin
               nst = ST_RELEASED; // RL14
               // baseline follows slow drift while idle
               if (raw_in > base_q[i]) begin
                  base_d[i] = base_q[i] + 16'h0001; // RL15
               end else if (raw_in < base_q[i]) begin
                  base_d[i] = base_q[i] - 16'h0001; // RL15
               end
            end
         end
         if (!ch_on[i]) begin
            nst = ST_RELEASED; // RL1
         end
         if (nst != ST_PRESSED) begin
            tmo_d[i] = '0;
         end
         st_d[i] = nst;
         // only enabled types on live channels flag the host
         if (ch_on[i] && nst != st_q[i] && evt_en[nst]) begin // RL5
            chg_d[i] = 1'b1; // RL4
         end
      end
      irq_d = |chg_d; // RL4 RL18
   end

   // registers only
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= S_SLEEP;
         ch_q <= 1'b0;
         start_q <= 1'b0;
         clk_sel_q <= CLK_SEL_RST;
         raw_q <= '0;
         base_q <= '0;
         peak_q <= '0;
         tmo_q <= '0;
         st_q <= {CH_N{ST_RELEASED}};
         wave_q <= {CH_N{WAVE_RST}};
         pend_q <= '0;
         done_q <= '0;
         chg_q <= '0;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ch_q <= ch_d;
         start_q <= start_d;
         clk_sel_q <= clk_sel_d;
         raw_q <= raw_d;
         base_q <= base_d;
         peak_q <= peak_d;
         tmo_q <= tmo_d;
         st_q <= st_d;
         wave_q <= wave_d;
         pend_q <= pend_d;
         done_q <= done_d;
         chg_q <= chg_d;
         irq_q <= irq_d;
      end
   end

   // outputs, each straight from a register
   assign irq = irq_q;
   assign acq_start = start_q;
   assign acq_ch = ch_q;
   assign core_clk_sel = clk_sel_q;
   assign cal_done = done_q;
   assign wave_sel = wave_q;
   assign sense_state = st_q;
   assign raw_val = raw_q;
   assign base_val = base_q;
   assign peak_val = peak_q;
endmodule // dual_touch_proximity_sense

/* File: tb/touch_host.sv */
// host model: open-drain bus master reading the mask and moving the address
`timescale 1ns/1ps
module touch_host (
   input wire logic clk, // core clock
   input wire logic dev_en, // block pulls data low
   output logic scl, // bus clock
   output logic sda // data wire with pull-up
);
   logic low_q = 1'b0; // host pulls data low
   // wired-and of both pull-downs against the pull-up
   assign sda = !(low_q || dev_en);
   initial scl = 1'b1;
   // one third of a bit period, five core cycles
   task automatic hold();
      repeat (5) @(posedge clk);
   endtask
   // one bit: data set while clock low, sampled at end of clock high
   task automatic bitx(input logic b, output logic r);
      low_q <= !b;
      hold();
      scl <= 1'b1;
      hold();
      r = sda;
      scl <= 1'b0;
      hold();
   endtask
   task automatic start();
      low_q <= 1'b1;
      hold();
      scl <= 1'b0;
      hold();
   endtask
   task automatic stop();
      low_q <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      low_q <= 1'b0;
      hold();
   endtask
   // eight data bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] t, input logic a,
      output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) begin
         bitx(t[i], r[i]);
      end
      bitx(a, k);
   endtask
   // read one mask byte, ending with a nack
   task automatic rd(input logic [6:0] a, output logic k,
      output logic [7:0] m);
      logic [7:0] x;
      logic k2;
      m = 8'h00;
      start();
      xfer({a, 1'b1}, 1'b1, x, k);
      if (!k) begin
         xfer(8'hff, 1'b1, m, k2);
      end
      stop();
   endtask
   // write one data byte carrying a new address
   task automatic wr(input logic [6:0] a, input logic [7:0] d,
      output logic k);
      logic [7:0] x;
      logic k2;
      k2 = 1'b0;
      start();
      xfer({a, 1'b0}, 1'b1, x, k);
      if (!k) begin
         xfer(d, 1'b1, x, k2);
      end
      k = k | k2;
      stop();
   endtask
endmodule // touch_host

/* File: tb/touch_chk.sv */
// checker: port timing relations of the touch block
`timescale 1ns/1ps
module touch_chk
   import touch_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic scl_pin, // bus clock
   input wire logic irq, // interrupt
   input wire logic ch1_en, // channel 1 on
   input wire logic clk_sel, // clock request
   input wire logic [TMO_W-1:0] press_tmo, // time-out
   input wire logic raw_valid, // result strobe
   input wire logic [RAW_W-1:0] raw_in, // result
   input wire logic peak_clr, // peak clear
   input wire logic acq_start, // start pulse
   input wire logic acq_ch, // channel
   input wire logic core_clk_sel, // chosen clock
   input wire logic [CH_N-1:0] cal_done, // calibrated
   input wire logic [CH_N-1:0] wave_sel, // waveform
   input wire logic [CH_N-1:0][1:0] sense_state, // states
   input wire logic [CH_N-1:0][RAW_W-1:0] raw_val, // raw
   input wire logic [CH_N-1:0][RAW_W-1:0] base_val, // baseline
   input wire logic [CH_N-1:0][RAW_W-1:0] peak_val // peak
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // port relations of scan, classification and notification
   AST_CLK_SEL: assert property (!$past(rst) |->
      core_clk_sel == $past(clk_sel)) else $error("clock select lag");
   AST_CH1_NEXT: assert property (raw_valid && !acq_ch && ch1_en
      |=> acq_start && acq_ch) else $error("channel 1 not started");
   AST_CH1_OFF: assert property (!ch1_en [*3] |->
      sense_state[1] == ST_RELEASED) else $error("channel 1 not idle");
   AST_TMO_OFF: assert property (sense_state[0] == ST_PRESSED &&
      press_tmo == 16'h0000 && !raw_valid |=>
      sense_state[0] == ST_PRESSED) else $error("press timed out");
   AST_PEAK_HI: assert property (raw_valid && !acq_ch && !peak_clr
      |=> peak_val[0] >= $past(raw_in)) else $error("peak below raw");
   AST_PEAK_CLR: assert property (peak_clr && !raw_valid |=>
      peak_val == '0) else $error("peak not cleared");
   AST_CAL_BASE: assert property ($rose(cal_done[0]) |->
      base_val[0] == raw_val[0] &&
      wave_sel[0] == (raw_val[0] < WAVE_LEVEL)) else $error("calibration");
   AST_IRQ_CAUSE: assert property ($rose(irq) |->
      sense_state != $past(sense_state) ||
      $past(sense_state) != $past(sense_state, 2)) else $error("stray irq");
   AST_IRQ_HOLD: assert property ((irq && scl_pin) [*8] |=> irq)
      else $error("irq dropped without read");
endmodule // touch_chk
bind dual_touch_proximity_sense touch_chk chk_u (.clk(clk), .rst(rst),
   .scl_pin(scl_pin), .irq(irq), .ch1_en(ch1_en), .clk_sel(clk_sel),
   .press_tmo(press_tmo), .raw_valid(raw_valid), .raw_in(raw_in),
   .peak_clr(peak_clr), .acq_start(acq_start), .acq_ch(acq_ch),
   .core_clk_sel(core_clk_sel), .cal_done(cal_done), .wave_sel(wave_sel),
   .sense_state(sense_state), .raw_val(raw_val), .base_val(base_val),
   .peak_val(peak_val));

/* File: tb/dual_touch_proximity_sense_tb.sv */
// bench: scans, events, mask reads and address change of the touch block
`timescale 1ns/1ps
module dual_touch_proximity_sense_tb;
   import touch_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ch1_en = 1'b1, clk_sel = 1'b0;
   logic peak_clr = 1'b0, raw_valid = 1'b0, raw_fault = 1'b0;
   logic [SLEEP_W-1:0] sleep_ms = 18'h00001;
   logic [RAW_W-1:0] press_th = 16'h0100, prox_th = 16'h0040;
   logic [RAW_W-1:0] raw_in = 16'h0000;
   logic [TMO_W-1:0] press_tmo = 16'h0000;
   logic [EVT_N-1:0] evt_en = 4'h7;
   logic [CH_N-1:0] cal_req = 2'h0;
   logic scl_pin, sda_pin, sda_val, sda_en, irq, acq_start, acq_ch;
   logic core_clk_sel;
   logic [6:0] slave_addr, ad = I2C_ADDR_RST;
   logic [CH_N-1:0] cal_done, wave_sel;
   logic [CH_N-1:0][1:0] sense_state;
   logic [CH_N-1:0][RAW_W-1:0] raw_val, base_val, peak_val;
   int failures = 0, comparisons = 0, seed = 5, cyc = 0;
   int req = 0, got = 0, wt = 0;
   int bs[2], pk[2], st[2], cg[2], wv[2], cd[2], pc[2], rw[2];
   dual_touch_proximity_sense #(.MS_CYC(10)) dut_u (.clk(clk), .rst(rst),
      .scl_pin(scl_pin), .sda_pin(sda_pin), .sda_val(sda_val),
      .sda_en(sda_en), .irq(irq), .slave_addr(slave_addr), .ch1_en(ch1_en),
      .clk_sel(clk_sel), .sleep_ms(sleep_ms), .press_th(press_th),
      .prox_th(prox_th), .press_tmo(press_tmo), .evt_en(evt_en),
      .cal_req(cal_req), .peak_clr(peak_clr), .acq_start(acq_start),
      .acq_ch(acq_ch), .raw_valid(raw_valid), .raw_in(raw_in),
      .raw_fault(raw_fault), .core_clk_sel(core_clk_sel),
      .cal_done(cal_done), .wave_sel(wave_sel), .sense_state(sense_state),
      .raw_val(raw_val), .base_val(base_val), .peak_val(peak_val));
   touch_host host_u (.clk(clk), .dev_en(sda_en), .scl(scl_pin),
      .sda(sda_pin));
   // 40 MHz clock
   initial forever #12.5 clk = ~clk;
   // count conversion starts, and cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (acq_start === 1'b1) req <= req + 1;
      if (cyc == 60000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude();
      if (failures == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask
   // reference: classify one result, track baseline, peak and events
   function automatic void model(int c, int r, logic f);
      int o, sh;
      o = st[c];
      rw[c] = r;
      if (r > pk[c]) pk[c] = r;
      sh = (r > bs[c]) ? r - bs[c] : 0;
      if (pc[c] != 0) begin
         bs[c] = r;
         wv[c] = (r < WAVE_LEVEL);
         cd[c] = 1;
         st[c] = 0;
         pc[c] = 0;
      end else if (f) st[c] = 3;
      else if (sh > press_th) st[c] = 1;
      else if (sh > prox_th) st[c] = 2;
      else begin
         st[c] = 0;
         bs[c] = bs[c] + (bs[c] < r) - (bs[c] > r);
      end
      if (st[c] != o && evt_en[st[c]]) cg[c] = 1;
   endfunction
   task automatic cmp_ch(int c);
      chk("state", st[c], sense_state[c]);
      chk("raw", rw[c], raw_val[c]);
      chk("base", bs[c], base_val[c]);
      chk("peak", pk[c], peak_val[c]);
      chk("wave", wv[c], wave_sel[c]);
      chk("cal", cd[c], cal_done[c]);
      chk("irq", cg[0] | cg[1], irq);
   endtask
   // answer one conversion start of channel c
   task automatic scan(input int c, input int r, input logic f);
      wt = 0;
      while (req == got && wt < 20000) begin
         @(posedge clk);
         #1;
         wt++;
      end
      got++;
      chk("acq_ch", c, acq_ch);
      repeat (1 + ($random(seed) & 3)) @(posedge clk);
      raw_valid <= 1'b1;
      raw_in <= r[15:0];
      raw_fault <= f;
      @(posedge clk);
      raw_valid <= 1'b0;
      #1;
      model(c, r & 'hffff, f);
      cmp_ch(c);
   endtask
   task automatic rdmask();
      logic ak;
      logic [7:0] m, e;
      e = {2'b00, cg[1][0], cg[0][0], st[1][1:0], st[0][1:0]};
      host_u.rd(ad, ak, m);
      chk("ack", 0, ak);
      chk("mask", e, m);
      cg = '{0, 0};
      chk("irq", 0, irq);
   endtask
   // main sequence
   initial begin
      logic ak;
      logic [7:0] m;
      repeat (2) @(posedge clk);
      #1;
      chk("addr", I2C_ADDR_RST, slave_addr);
      chk("clk", CLK_SEL_RST, core_clk_sel);
      chk("sda_val", 0, sda_val);
      @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         clk_sel <= k[0];
         repeat (2) @(posedge clk);
         #1;
         chk("clk", k, core_clk_sel);
      end
      @(posedge clk);
      cal_req <= 2'h3;
      @(posedge clk);
      cal_req <= 2'h0;
      pc = '{1, 1};
      scan(0, 'h1000, 0);
      scan(1, 'h3000, 0);
      scan(0, 'h1100, 0);
      scan(1, 'h3040, 0);
      scan(0, 'h1101, 0);
      scan(1, 'h3042, 0);
      rdmask();
      press_tmo <= 16'h0003;
      repeat (5) @(posedge clk);
      #1;
      st[0] = 0;
      bs[0] = rw[0];
      cg[0] = 1;
      cmp_ch(0);
      sleep_ms <= 18'h003e8;
      scan(0, 'h1202, 0);
      scan(1, 'h3001, 0);
      repeat (50) @(posedge clk);
      #1;
      st[0] = 0;
      bs[0] = rw[0];
      cmp_ch(0);
      rdmask();
      // keep the long interval until its scan arrives, then shorten it
      press_tmo <= 16'h0000;
      scan(0, 'h1000, 1);
      chk("sleep", 1, wt > 9000 && wt < 10010);
      sleep_ms <= 18'h00001;
      scan(1, 'h3001, 0);
      @(posedge clk);
      peak_clr <= 1'b1;
      @(posedge clk);
      peak_clr <= 1'b0;
      pk = '{0, 0};
      @(posedge clk);
      #1;
      chk("peak", 0, peak_val);
      evt_en <= 4'hf;
      for (int k = 0; k < 8; k++) begin
         scan(0, bs[0] + ($random(seed) & 'h1ff) - 'h40,
            ($random(seed) & 7) == 0);
         scan(1, bs[1] + ($random(seed) & 'h1ff) - 'h40, 0);
         if (cg[0] || cg[1]) rdmask();
      end
      ch1_en <= 1'b0;
      st[1] = 0;
      repeat (3) @(posedge clk);
      #1;
      chk("state1", 0, sense_state[1]);
      scan(0, bs[0], 0);
      scan(0, bs[0], 0);
      host_u.wr(ad, 8'h3a, ak);
      chk("ack", 0, ak);
      ad = 7'h3a;
      chk("addr", ad, slave_addr);
      host_u.rd(I2C_ADDR_RST, ak, m);
      chk("nack", 1, ak);
      rdmask();
      conclude();
   end
endmodule // dual_touch_proximity_sense_tb
